// *** rtl/supervisor_pkg.sv ***
package supervisor_pkg;
    // register indices
    localparam logic [3:0] REG_WD_JOIN_CFG   = 4'h3;
    localparam logic [3:0] REG_SLOW_OV_STAT  = 4'h7;
    // config register 3 fields
    localparam int WD_SEL_LSB       = 0;
    localparam int FLT_PULSE_OFF_BIT = 4;
    localparam logic [7:0] CFG3_RESET = 8'h00;
    localparam logic [1:0] WD_SEL_0P90 = 2'h0;
    localparam logic [1:0] WD_SEL_0P45 = 2'h1;
    localparam logic [1:0] WD_SEL_0P15 = 2'h2;
    // timing
    localparam int CLK_HZ          = 100_000_000;
    localparam int PRESCALE_CYC    = 100_000;      // 1 ms tick
    localparam int WD_0P90_MS      = 900;
    localparam int WD_0P45_MS      = 450;
    localparam int WD_0P15_MS      = 150;
    localparam int SC_PULSE_US     = 100;
    localparam int SC_PULSE_CYC    = SC_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int SLOW_HS_MS      = 15;
    localparam int SLOW_PP_MS      = 20;
    localparam int FILT_CYC        = 4;
    localparam int LED_PHASE_CYC   = 1_000;
endpackage

// *** rtl/octal_driver_fault_supervisor.sv ***
`timescale 1ns/1ps
// Functional notes
// - watchdog restarts on every chip-select falling edge
// - on expiry all outputs off, timeout flag low until next select fall
// - timeout field: 00 0.9 s, 01 0.45 s, 10 0.15 s; resets to 0.9 s
// - driver overtemp turns channel off; re-enables when indication clears
// - driver overtemp: global fault and fault led
// - chip overtemp shuts all channels and asserts global fault
// - short circuit pulses global fault for about 100 us
// - register 3 bit 4 suppresses the short pulse, command-mode writes only
// - short circuit puts channel into slow slew mode
// - high-side channel leaves slow mode automatically after 10-20 ms
// - output enable low clears slow mode on all channels
// - 16-bit/command with config select high returns slow status in low byte
// - register 7 reports per-channel slow-mode status
// - undervoltage three-states outputs, disables open-load, flags pin
// - lit fault led forces level led off
// - serial mode, config select high: level led shows slow mode
// - 4x4 led matrix scanned one row at a time, 25% duty
// - push-pull pin 0 high-side unless serial set; 1 forces push-pull
// - serial mode open-load pin 1 enables all high-side; else per channel
// - deglitch pin filters inputs; push-pull and setting-mode always filtered
// - output enable low turns drivers and leds off
module octal_driver_fault_supervisor #(
    parameter int PRESCALE = supervisor_pkg::PRESCALE_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_cs_n,
    input  wire logic       i_supervision_enable_pin,
    input  wire logic       i_setting_mode_select_pin,
    input  wire logic       i_configuration_select_pin,
    input  wire logic       i_push_pull_select_pin,
    input  wire logic       i_global_open_load_pin,
    input  wire logic       i_deglitch_select_pin,
    input  wire logic       i_output_enable_pin,
    input  wire logic       i_wide_frame,
    input  wire logic       i_command_mode,
    input  wire logic [7:0] i_chan_in,
    input  wire logic [7:0] i_serial_pp_cfg,
    input  wire logic [7:0] i_serial_ol_cfg,
    input  wire logic [7:0] i_driver_overtemp,
    input  wire logic       i_chip_overtemp,
    input  wire logic [7:0] i_short_detect,
    input  wire logic [2:0] i_undervoltage,
    input  wire logic       i_reg_we,
    input  wire logic [3:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    output logic      [7:0] o_diag_low_byte,
    output logic      [7:0] o_chan_on,
    output logic      [7:0] o_chan_push_pull,
    output logic      [7:0] o_chan_slow,
    output logic      [7:0] o_open_load_en,
    output logic            o_fault_out,
    output logic            o_fault_oe,
    output logic            o_supervision_timeout_flag_pin,
    output logic            o_timeout_flag_oe,
    output logic            o_undervoltage_flag_pin,
    output logic      [3:0] o_led_row,
    output logic      [3:0] o_led_col
);
    // ----------------------------------------
    // input synchronisers and deglitch
    // ----------------------------------------
    localparam int NS = 28;
    logic [NS-1:0] s1_r, s2_r, flt_r, flt_nxt;
    logic [NS-1:0] raw;
    logic [2:0]    fcnt_r [NS];
    logic [2:0]    fcnt_nxt [NS];
    logic [NS-1:0] always_filt;
    logic          i_deglitch_select_pin_s;

    assign i_deglitch_select_pin_s = s2_r[21];

    assign raw = {i_cs_n, i_supervision_enable_pin, i_setting_mode_select_pin,
                  i_configuration_select_pin, i_push_pull_select_pin,
                  i_global_open_load_pin, i_deglitch_select_pin,
                  i_output_enable_pin, i_chan_in, i_driver_overtemp, i_chip_overtemp,
                  i_undervoltage};
    assign always_filt = {2'b00, 1'b1, 1'b0, 1'b1, 23'h0};

    always_comb begin
        for (int i = 0; i < NS; i++) begin
            fcnt_nxt[i] = fcnt_r[i];
            flt_nxt[i]  = flt_r[i];
            if (!(i_deglitch_select_pin_s || always_filt[i])) begin
                flt_nxt[i]  = s2_r[i];
                fcnt_nxt[i] = 3'h0;
            end else if (s2_r[i] == flt_r[i]) begin
                fcnt_nxt[i] = 3'h0;
            end else if (fcnt_r[i] == 3'(supervisor_pkg::FILT_CYC - 1)) begin
                flt_nxt[i]  = s2_r[i];
                fcnt_nxt[i] = 3'h0;
            end else begin
                fcnt_nxt[i] = fcnt_r[i] + 3'h1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_r  <= {1'b1, 27'h0};
            s2_r  <= {1'b1, 27'h0};
            flt_r <= {1'b1, 27'h0};
            for (int i = 0; i < NS; i++) fcnt_r[i] <= 3'h0;
        end else begin
            s1_r  <= raw;
            s2_r  <= s1_r;
            flt_r <= flt_nxt;
            for (int i = 0; i < NS; i++) fcnt_r[i] <= fcnt_nxt[i];
        end
    end

    logic       cs_n, wd_en, serial_mode, cfg_sel, pp_pin, ol_pin, oe_pin, chip_ot;
    logic [7:0] chan_in, drv_ot;
    logic [2:0] uv;
    assign {cs_n, wd_en, serial_mode, cfg_sel, pp_pin, ol_pin} = flt_r[27:22];
    assign oe_pin  = flt_r[20];
    assign chan_in = flt_r[19:12];
    assign drv_ot  = flt_r[11:4];
    assign chip_ot = flt_r[3];
    assign uv      = flt_r[2:0];

    // ----------------------------------------
    // registers, watchdog, slow mode, fault pulse
    // ----------------------------------------
    logic [7:0]  cfg3_r, cfg3_nxt, slow_r, slow_nxt, sc_prev_r;
    logic        cs_prev_r, wd_fault_r, wd_fault_nxt;
    logic [16:0] pre_r, pre_nxt;
    logic [9:0]  wd_ms_r, wd_ms_nxt, wd_limit;
    logic [4:0]  slow_ms_r [8];
    logic [4:0]  slow_ms_nxt [8];
    logic [13:0] sc_cnt_r, sc_cnt_nxt;
    logic        tick, cs_fall;
    logic [7:0]  pp_mode, sc_rise;

    assign tick    = (pre_r == 17'(PRESCALE - 1));
    assign cs_fall = cs_prev_r && !cs_n;
    assign sc_rise = i_short_detect & ~sc_prev_r;
    assign pp_mode = pp_pin ? 8'hff : i_serial_pp_cfg;

    always_comb begin
        unique case (cfg3_r[supervisor_pkg::WD_SEL_LSB +: 2])
            supervisor_pkg::WD_SEL_0P45: wd_limit = 10'(supervisor_pkg::WD_0P45_MS);
            supervisor_pkg::WD_SEL_0P15: wd_limit = 10'(supervisor_pkg::WD_0P15_MS);
            default:                     wd_limit = 10'(supervisor_pkg::WD_0P90_MS);
        endcase
    end

    always_comb begin
        cfg3_nxt     = cfg3_r;
        pre_nxt      = tick ? 17'h0 : pre_r + 17'h1;
        wd_ms_nxt    = wd_ms_r;
        wd_fault_nxt = wd_fault_r;
        slow_nxt     = slow_r;
        sc_cnt_nxt   = (sc_cnt_r != 14'h0) ? sc_cnt_r - 14'h1 : 14'h0;
        if (i_reg_we && i_command_mode && i_reg_addr == supervisor_pkg::REG_WD_JOIN_CFG)
            cfg3_nxt = i_reg_wdata;
        if (cs_fall || !(wd_en && serial_mode)) begin
            wd_ms_nxt    = 10'h0;
            wd_fault_nxt = 1'b0;
        end else if (tick) begin
            if (wd_ms_r >= wd_limit - 10'h1) wd_fault_nxt = 1'b1;
            else wd_ms_nxt = wd_ms_r + 10'h1;
        end
        if ((|sc_rise) && !cfg3_r[supervisor_pkg::FLT_PULSE_OFF_BIT])
            sc_cnt_nxt = 14'(supervisor_pkg::SC_PULSE_CYC);
        for (int c = 0; c < 8; c++) begin
            slow_ms_nxt[c] = slow_ms_r[c];
            if (!oe_pin) begin
                slow_nxt[c]    = 1'b0;
                slow_ms_nxt[c] = 5'h0;
            end else if (i_short_detect[c]) begin
                slow_nxt[c]    = 1'b1;
                slow_ms_nxt[c] = 5'h0;
            end else if (slow_r[c]) begin
                if (pp_mode[c] && chan_in[c]) begin
                    slow_ms_nxt[c] = 5'h0;
                end else if (tick) begin
                    if (slow_ms_r[c] >= (pp_mode[c] ? 5'(supervisor_pkg::SLOW_PP_MS)
                                                     : 5'(supervisor_pkg::SLOW_HS_MS)))
                        slow_nxt[c] = 1'b0;
                    else
                        slow_ms_nxt[c] = slow_ms_r[c] + 5'h1;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg3_r     <= supervisor_pkg::CFG3_RESET;
            pre_r      <= 17'h0;
            wd_ms_r    <= 10'h0;
            wd_fault_r <= 1'b0;
            slow_r     <= 8'h00;
            sc_cnt_r   <= 14'h0;
            sc_prev_r  <= 8'h00;
            cs_prev_r  <= 1'b1;
            for (int c = 0; c < 8; c++) slow_ms_r[c] <= 5'h0;
        end else begin
            cfg3_r     <= cfg3_nxt;
            pre_r      <= pre_nxt;
            wd_ms_r    <= wd_ms_nxt;
            wd_fault_r <= wd_fault_nxt;
            slow_r     <= slow_nxt;
            sc_cnt_r   <= sc_cnt_nxt;
            sc_prev_r  <= i_short_detect;
            cs_prev_r  <= cs_n;
            for (int c = 0; c < 8; c++) slow_ms_r[c] <= slow_ms_nxt[c];
        end
    end

    // ----------------------------------------
    // output gating, status and led scan
    // ----------------------------------------
    logic [1:0]  row_r, row_nxt;
    logic [9:0]  ph_r, ph_nxt;
    logic [7:0]  on_nxt, fault_led, level_led;
    logic [15:0] leds;
    logic [3:0]  col_nxt;
    logic        uv_any, kill_all;

    assign uv_any    = |uv;
    assign kill_all  = wd_fault_r || chip_ot || uv_any || !oe_pin;
    assign on_nxt    = kill_all ? 8'h00 : (chan_in & ~drv_ot);
    assign fault_led = drv_ot;
    assign level_led = (serial_mode && cfg_sel) ? slow_r : chan_in;
    assign leds      = oe_pin ? {fault_led, level_led & ~fault_led} : 16'h0;

    always_comb begin
        ph_nxt  = (ph_r == 10'(supervisor_pkg::LED_PHASE_CYC - 1)) ? 10'h0 : ph_r + 10'h1;
        row_nxt = (ph_r == 10'(supervisor_pkg::LED_PHASE_CYC - 1)) ? row_r + 2'h1 : row_r;
        col_nxt = leds[{row_r, 2'b00} +: 4];
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ph_r <= 10'h0;
            row_r <= 2'h0;
            o_led_row <= 4'h0;
            o_led_col <= 4'h0;
            o_chan_on <= 8'h00;
            o_chan_push_pull <= 8'h00;
            o_chan_slow <= 8'h00;
            o_open_load_en <= 8'h00;
            o_fault_out <= 1'b1;
            o_fault_oe <= 1'b0;
            o_supervision_timeout_flag_pin <= 1'b1;
            o_timeout_flag_oe <= 1'b0;
            o_undervoltage_flag_pin <= 1'b0;
            o_reg_rdata <= 8'h00;
            o_diag_low_byte <= 8'h00;
        end else begin
            ph_r <= ph_nxt;
            row_r <= row_nxt;
            o_led_row <= 4'h1 << row_r;
            o_led_col <= col_nxt;
            o_chan_on <= on_nxt;
            o_chan_push_pull <= pp_mode;
            o_chan_slow <= slow_r;
            o_open_load_en <= (uv_any || kill_all) ? 8'h00 :
                ((serial_mode && ol_pin) ? ~pp_mode : i_serial_ol_cfg & ~pp_mode);
            o_fault_out <= 1'b0;
            o_fault_oe <= (|drv_ot) || chip_ot || (sc_cnt_r != 14'h0);
            o_supervision_timeout_flag_pin <= 1'b0;
            o_timeout_flag_oe <= wd_fault_r;
            o_undervoltage_flag_pin <= uv_any;
            o_reg_rdata <= (i_reg_addr == supervisor_pkg::REG_SLOW_OV_STAT) ? slow_r :
                           (i_reg_addr == supervisor_pkg::REG_WD_JOIN_CFG) ? cfg3_r : 8'h00;
            o_diag_low_byte <= ((i_wide_frame || i_command_mode) && cfg_sel) ? slow_r
                                                                              : chan_in;
        end
    end
endmodule // octal_driver_fault_supervisor

// *** sim/spi_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// host side: one chip-select frame per go
// ----------------------------------------
module spi_host_model #(
    parameter int LINK_NS = 160
) (
    input  wire logic i_go,
    output logic      o_cs_n
);
    // serial clock stands still between frames, so only select is modelled
    initial o_cs_n = 1'b1;
    always @(posedge i_go) begin
        o_cs_n = 1'b0;
        #(8 * LINK_NS);
        o_cs_n = 1'b1;
    end
endmodule // spi_host_model

// *** sim/supervisor_props.sv ***
`timescale 1ns/1ps
module supervisor_props #(
    parameter int PRESCALE = 10
) (
    input wire logic       i_clk,
    input wire logic       i_resetn,
    input wire logic       i_output_enable_pin,
    input wire logic       i_push_pull_select_pin,
    input wire logic       i_command_mode,
    input wire logic       i_chip_overtemp,
    input wire logic [7:0] i_short_detect,
    input wire logic [2:0] i_undervoltage,
    input wire logic       i_reg_we,
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [7:0] o_chan_on,
    input wire logic [7:0] o_chan_push_pull,
    input wire logic [7:0] o_chan_slow,
    input wire logic       o_fault_oe,
    input wire logic       o_timeout_flag_oe,
    input wire logic       o_undervoltage_flag_pin,
    input wire logic [3:0] o_led_row,
    input wire logic [3:0] o_led_col
);
    // ----------------------------------------
    // shadow of the pulse-suppress bit
    // ----------------------------------------
    logic pulse_off_r;
    logic pulse_off_nxt;
    always_comb begin
        pulse_off_nxt = pulse_off_r;
        if (i_reg_we && i_command_mode && i_reg_addr == supervisor_pkg::REG_WD_JOIN_CFG) begin
            pulse_off_nxt = i_reg_wdata[supervisor_pkg::FLT_PULSE_OFF_BIT];
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pulse_off_r <= 1'b0;
        end else begin
            pulse_off_r <= pulse_off_nxt;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    chk_uv_lockout: assert property ((|i_undervoltage)[*8] |-> ##1
        (o_chan_on == 8'h00 && o_undervoltage_flag_pin)) else $error("outputs live in undervoltage");
    chk_chip_hot: assert property (i_chip_overtemp[*8] |-> ##1
        (o_chan_on == 8'h00 && o_fault_oe)) else $error("chip overtemp not handled");
    chk_enable_low: assert property ((!i_output_enable_pin)[*8] |-> ##1
        (o_chan_slow == 8'h00 && o_chan_on == 8'h00 && o_led_col == 4'h0)) else $error("enable low ignored");
    chk_led_scan: assert property ($onehot0(o_led_row)) else $error("two led rows on");
    chk_short_slow: assert property ($rose(i_short_detect[0]) && i_output_enable_pin |->
        ##2 o_chan_slow[0]) else $error("short did not set slow mode");
    chk_short_pulse: assert property ($rose(i_short_detect[0]) && !pulse_off_r |->
        ##2 o_fault_oe[*8]) else $error("short pulse missing");
    chk_timeout_off: assert property (o_timeout_flag_oe[*2] |-> o_chan_on == 8'h00)
        else $error("outputs on after timeout");
    chk_slow_reg: assert property (i_reg_addr == supervisor_pkg::REG_SLOW_OV_STAT && $stable(i_reg_addr)
        && $stable(o_chan_slow) |-> o_reg_rdata == o_chan_slow) else $error("slow register wrong");
    chk_pp_force: assert property (i_push_pull_select_pin[*8] |-> ##1 o_chan_push_pull == 8'hff)
        else $error("push-pull not forced");
    cov_short: cover property ($rose(i_short_detect[0]) ##2 o_fault_oe);
    cov_timeout: cover property ($rose(o_timeout_flag_oe));
    cov_uv: cover property ($rose(o_undervoltage_flag_pin));
endmodule // supervisor_props
bind octal_driver_fault_supervisor supervisor_props #(.PRESCALE(PRESCALE)) supervisor_props_inst (.*);

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    localparam int P = 10;
    logic       i_clk, i_resetn, i_cs_n, i_supervision_enable_pin, i_setting_mode_select_pin;
    logic       i_configuration_select_pin, i_push_pull_select_pin, i_global_open_load_pin;
    logic       i_deglitch_select_pin, i_output_enable_pin, i_wide_frame, i_command_mode;
    logic       i_chip_overtemp, i_reg_we, go, o_fault_out, o_fault_oe, o_undervoltage_flag_pin;
    logic       o_supervision_timeout_flag_pin, o_timeout_flag_oe;
    logic [7:0] i_chan_in, i_serial_pp_cfg, i_serial_ol_cfg, i_driver_overtemp, i_short_detect;
    logic [7:0] i_reg_wdata, o_reg_rdata, o_diag_low_byte, o_chan_on, o_chan_push_pull;
    logic [7:0] o_chan_slow, o_open_load_en, seed, d;
    logic [3:0] i_reg_addr, o_led_row, o_led_col;
    logic [2:0] i_undervoltage;
    int         num_errors, samples_checked, cycles, n_flt, n_slow, n;
    int         cfg3_m;
    int         wd_ms[$] = '{supervisor_pkg::WD_0P15_MS, supervisor_pkg::WD_0P45_MS,
                             supervisor_pkg::WD_0P90_MS};
    octal_driver_fault_supervisor #(.PRESCALE(P)) octal_driver_fault_supervisor_inst (.*);
    spi_host_model spi_host_model_inst (.i_go(go), .o_cs_n(i_cs_n));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic close_out();
        if (num_errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] v);
        i_reg_addr = 4'h3;
        i_reg_wdata = v;
        i_reg_we = 1'b1;
        tick(1);
        i_reg_we = 1'b0;
        if (i_command_mode) cfg3_m = v;
    endtask
    task automatic rd(input logic [3:0] a);
        i_reg_addr = a;
        tick(2);
        d = o_reg_rdata;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        {i_resetn, i_supervision_enable_pin, i_configuration_select_pin, go} = 4'h0;
        {i_push_pull_select_pin, i_global_open_load_pin, i_wide_frame, i_command_mode} = 4'h0;
        {i_chip_overtemp, i_reg_we, i_chan_in, i_serial_ol_cfg, i_driver_overtemp} = 26'h0;
        {i_short_detect, i_reg_wdata, i_reg_addr, i_undervoltage, i_serial_pp_cfg} = 31'h0;
        {i_setting_mode_select_pin, i_deglitch_select_pin, i_output_enable_pin} = 3'h7;
        seed = 8'h20;
        cfg3_m = 0;
        repeat (5) @(posedge i_clk);
        #1 i_resetn = 1'b1;
        tick(2);
        rd(4'h3); check(d, cfg3_m);
        rd(4'h5); check(d, 8'h00);
        seed = lfsr(seed); i_serial_pp_cfg = seed & 8'hfe; seed = lfsr(seed); i_chan_in = seed;
        i_serial_ol_cfg = lfsr(seed);
        tick(12); check(o_chan_push_pull, i_serial_pp_cfg);
        i_push_pull_select_pin = 1'b1; tick(12); check(o_chan_push_pull, 8'hff);
        i_push_pull_select_pin = 1'b0;
        {i_command_mode, i_wide_frame, i_configuration_select_pin} = 3'h7;
        i_reg_addr = 4'h7;
        tick(12);
        i_short_detect = 8'h01; n_flt = 0; n_slow = 0;
        for (int i = 0; i < 11000; i++) begin
            tick(1); n_flt += o_fault_oe; n_slow += o_chan_slow[0];
            if (i == 0) i_short_detect = 8'h00;
            if (i == 5) check(o_reg_rdata, 8'h01);
            if (i == 5) check(o_diag_low_byte, 8'h01);
        end
        check(n_flt >= supervisor_pkg::SC_PULSE_CYC - 3 && n_flt <= supervisor_pkg::SC_PULSE_CYC + 3, 1'h1);
        check(n_slow >= 10 * P && n_slow <= 20 * P, 1'h1);
        i_short_detect = 8'h00; wr(8'h10); tick(2);
        i_short_detect = 8'h02; n_flt = 0;
        for (int i = 0; i < 50; i++) begin
            tick(1); n_flt += o_fault_oe;
            if (i == 5) check(o_chan_slow, 8'h02);
        end
        check(n_flt, 0);
        i_output_enable_pin = 1'b0; tick(12);
        check(o_chan_slow, 8'h00);
        check(o_led_col, 4'h0);
        i_output_enable_pin = 1'b1; i_short_detect = 8'h00;
        i_push_pull_select_pin = 1'b1; i_chan_in = 8'h00; tick(12);
        i_short_detect = 8'h04; tick(1); i_short_detect = 8'h00;
        tick(180); check(o_chan_slow[2], 1'h1);
        tick(60); check(o_chan_slow[2], 1'h0);
        i_push_pull_select_pin = 1'b0; i_chan_in = seed;
        i_command_mode = 1'b0; wr(8'h12); i_command_mode = 1'b1;
        rd(4'h3); check(d, cfg3_m);
        i_undervoltage = 3'h2; tick(12);
        check({o_undervoltage_flag_pin, o_chan_on, o_open_load_en}, 17'h1_0000);
        i_undervoltage = 3'h0; i_chip_overtemp = 1'b1; tick(12);
        check({o_fault_oe, o_chan_on}, 9'h100);
        i_chip_overtemp = 1'b0; i_driver_overtemp = 8'h08; tick(12);
        check(o_chan_on[3], 1'h0);
        check(o_fault_oe, 1'h1);
        i_driver_overtemp = 8'h00; tick(12);
        i_supervision_enable_pin = 1'b1;
        for (int k = 0; k < 3; k++) begin
            wr(8'h10 | (2 - k));
            go = 1'b1; tick(1); go = 1'b0; n = 0;
            while (o_timeout_flag_oe !== 1'b1 && n < 10000) begin
                tick(1); n++;
            end
            check(n >= (wd_ms[k] - 2) * P && n <= (wd_ms[k] + 3) * P, 1'h1);
            check(o_chan_on, 8'h00);
            go = 1'b1; tick(1); go = 1'b0; tick(12);
            check(o_timeout_flag_oe, 1'h0);
            tick(130);
        end
        close_out();
    end
endmodule // tb_top
